//--- pport_consts.vh
// Constants for the parallel port host register block
`ifndef PPORT_CONSTS_VH
`define PPORT_CONSTS_VH
`define OFS_DATA        3'h0
`define OFS_STATUS      3'h1
`define OFS_CONTROL     3'h2
`define OFS_EPP_ADDR    3'h3
`define OFS_EPP_DATA0   3'h4
`define STS_TIMEOUT     0
`define STS_FAULT       3
`define STS_ONLINE      4
`define STS_MEDIA       5
`define STS_ACK         6
`define STS_READY       7
`define CTL_STROBE      0
`define CTL_FEED        1
`define CTL_INIT        2
`define CTL_SELIN       3
`define CTL_IRQEN       4
`define CTL_DIR         5
`define DATA_RST        8'h00
`define CTRL_RST        6'h00
`define MODE_PRINTER    2'h0
`define MODE_BIDIR      2'h1
`define MODE_EPP        2'h2
`define CLK_MHZ         250
`define EPP_TMO_US      10
`define EPP_TMO_CYC     (`EPP_TMO_US * `CLK_MHZ)
`endif

//--- word_buffer.v
// Two-entry valid/ready buffer for read data
`timescale 1ns/1ps
`default_nettype none
module word_buffer (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst_n,
  // Fill side
  input  wire       inValid,
  output wire       inReady,
  input  wire [7:0] inData,
  // Drain side
  output wire       outValid,
  input  wire       outReady,
  output reg  [7:0] outData
);
  reg [7:0] slot1Q;
  reg [1:0] countQ;
  wire      push;
  wire      pop;
  assign inReady  = (countQ != 2'h2);
  assign outValid = (countQ != 2'h0);
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  // Head register feeds outData directly; slot1 holds the overflow word
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      countQ  <= 2'h0;
      outData <= 8'h00;
      slot1Q  <= 8'h00;
    end else begin
      if (push && !pop) begin
        countQ <= countQ + 2'h1;
        if (countQ == 2'h0)
          outData <= inData;
        else
          slot1Q <= inData;
      end else if (pop && !push) begin
        countQ  <= countQ - 2'h1;
        outData <= slot1Q;
      end else if (push && pop) begin
        if (countQ == 2'h1)
          outData <= inData;
        else begin
          outData <= slot1Q;
          slot1Q  <= inData;
        end
      end
    end
  end
endmodule // word_buffer
`default_nettype wire

//--- parallel_port_regs.v
// Host register block of a multi-mode parallel port
`timescale 1ns/1ps
`default_nettype none
`include "pport_consts.vh"
module parallel_port_regs #(
  parameter [11:0] EPP_TMO_CYCLES = `EPP_TMO_CYC
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst_n,
  // Mode selection from configuration
  input  wire [1:0] portMode,
  // Host access port
  input  wire       hostReq,
  input  wire       hostWrite,
  input  wire [2:0] hostAddr,
  input  wire [7:0] hostWdata,
  output wire       hostReady,
  output wire       rdValid,
  input  wire       rdReady,
  output wire [7:0] rdData,
  // Parallel data lines
  input  wire [7:0] pdIn,
  output reg  [7:0] pdOut,
  output reg        pdOe,
  // Peripheral status inputs
  input  wire       faultInput,
  input  wire       onlineInput,
  input  wire       mediaInput,
  input  wire       ackInput,
  input  wire       busyInput,
  input  wire       waitInput,
  // Printer control outputs (active low where noted)
  output reg        strobeOut_n,
  output reg        lineFeedOut_n,
  output reg        initOut,
  output reg        selectInOut_n,
  output reg        irqEnable,
  // EPP strobes
  output reg        eppWriteOut_n,
  output reg        eppDataStbOut_n,
  output reg        eppAddrStbOut_n
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAITLO = 2'h1;
  localparam [1:0] ST_STB = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;

  reg  [7:0]  dataQ;
  reg  [5:0]  ctrlQ;
  reg         timeoutQ;
  reg  [7:0]  eppLatchQ;
  reg  [1:0]  stQ;
  reg  [11:0] tmrQ;
  reg         eppWrQ;
  reg         eppAddrQ;
  reg  [7:0]  pdS1Q, pdS2Q;
  reg  [5:0]  inS1Q, inS2Q;
  reg  [7:0]  statusSnap;
  reg  [7:0]  rdMux;
  wire        eppMode;
  wire        isEppPort;
  wire        bufReady;
  wire        access;
  wire        eppStart;
  wire        eppBusy;
  wire        pushRd;
  wire        eppTimeout;
  wire        eppFinish;
  wire [7:0]  ctrlByte;

  assign eppMode   = (portMode == `MODE_EPP);
  assign isEppPort = (hostAddr >= `OFS_EPP_ADDR);
  assign eppBusy   = (stQ != ST_IDLE);
  // Host stalls while an EPP cycle runs or the read buffer is full
  assign hostReady = bufReady & ~eppBusy;
  assign access    = hostReq & hostReady;
  assign eppStart  = access & isEppPort & eppMode;
  assign ctrlByte  = {2'b00, ctrlQ};
  assign eppTimeout = eppBusy && (stQ != ST_DONE) && (tmrQ == EPP_TMO_CYCLES);
  assign eppFinish  = (stQ == ST_DONE) | eppTimeout;

  // Two-flop synchronisers on all cable inputs
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pdS1Q <= 8'h00;
      pdS2Q <= 8'h00;
      inS1Q <= 6'h00;
      inS2Q <= 6'h00;
    end else begin
      pdS1Q <= pdIn;
      pdS2Q <= pdS1Q;
      inS1Q <= {waitInput, busyInput, ackInput, mediaInput, onlineInput, faultInput};
      inS2Q <= inS1Q;
    end
  end

  // Status image, sampled on the single read cycle and then held in the buffer
  always @* begin
    statusSnap = 8'h00;
    statusSnap[`STS_TIMEOUT] = timeoutQ & eppMode;
    statusSnap[`STS_FAULT]   = inS2Q[0];
    statusSnap[`STS_ONLINE]  = inS2Q[1];
    statusSnap[`STS_MEDIA]   = inS2Q[2];
    statusSnap[`STS_ACK]     = inS2Q[3];
    statusSnap[`STS_READY]   = ~inS2Q[4];
  end

  // Read data selection for non-EPP ports
  always @* begin
    case (hostAddr)
      `OFS_DATA: rdMux = (eppMode || portMode == `MODE_BIDIR) && ctrlQ[`CTL_DIR] ? pdS2Q
                         : (portMode == `MODE_PRINTER ? pdS2Q : pdS2Q);
      `OFS_STATUS:  rdMux = statusSnap;
      `OFS_CONTROL: rdMux = ctrlByte;
      default:      rdMux = 8'h00;
    endcase
  end

  // Reads push a byte now, except EPP reads which push when the cycle ends
  assign pushRd = (access & ~hostWrite & ~eppStart) | (eppFinish & ~eppWrQ);

  word_buffer u_rdbuf (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .inValid  (pushRd),
    .inReady  (bufReady),
    .inData   (eppFinish ? (eppTimeout ? 8'h00 : eppLatchQ) : rdMux),
    .outValid (rdValid),
    .outReady (rdReady),
    .outData  (rdData)
  );

  // Host-visible registers
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataQ    <= `DATA_RST;
      ctrlQ    <= `CTRL_RST;
      timeoutQ <= 1'b0;
    end else begin
      if (access && hostWrite && hostAddr == `OFS_DATA)
        dataQ <= hostWdata;
      if (access && hostWrite && hostAddr == `OFS_CONTROL)
        ctrlQ <= hostWdata[5:0];
      // A timeout in the same cycle as a clear write wins
      if (eppTimeout)
        timeoutQ <= 1'b1;
      else if (access && hostWrite && eppMode && hostAddr == `OFS_STATUS &&
               hostWdata[`STS_TIMEOUT])
        timeoutQ <= 1'b0;
    end
  end

  // EPP cycle engine with watchdog; minimal handshake on the wait line
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stQ       <= ST_IDLE;
      tmrQ      <= 12'h000;
      eppWrQ    <= 1'b0;
      eppAddrQ  <= 1'b0;
      eppLatchQ <= 8'h00;
    end else begin
      case (stQ)
        ST_IDLE: begin
          tmrQ <= 12'h000;
          if (eppStart) begin
            eppWrQ    <= hostWrite;
            eppAddrQ  <= (hostAddr == `OFS_EPP_ADDR);
            eppLatchQ <= hostWdata;
            stQ       <= inS2Q[5] ? ST_WAITLO : ST_STB;
          end
        end
        ST_WAITLO: begin
          tmrQ <= tmrQ + 12'h001;
          if (eppTimeout)
            stQ <= ST_IDLE;
          else if (!inS2Q[5])
            stQ <= ST_STB;
        end
        ST_STB: begin
          tmrQ <= tmrQ + 12'h001;
          if (eppTimeout)
            stQ <= ST_IDLE;
          else if (inS2Q[5]) begin
            if (!eppWrQ)
              eppLatchQ <= pdS2Q;
            stQ <= ST_DONE;
          end
        end
        ST_DONE: stQ <= ST_IDLE;
        default: stQ <= ST_IDLE;
      endcase
    end
  end

  // Cable outputs from flops
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pdOut           <= 8'h00;
      pdOe            <= 1'b1;
      strobeOut_n     <= 1'b1;
      lineFeedOut_n   <= 1'b1;
      initOut         <= 1'b0;
      selectInOut_n   <= 1'b1;
      irqEnable       <= 1'b0;
      eppWriteOut_n   <= 1'b1;
      eppDataStbOut_n <= 1'b1;
      eppAddrStbOut_n <= 1'b1;
    end else begin
      pdOut <= (stQ == ST_STB && eppWrQ) ? eppLatchQ : dataQ;
      if (portMode == `MODE_PRINTER)
        pdOe <= 1'b1;
      else if (stQ == ST_STB)
        pdOe <= eppWrQ | ctrlQ[`CTL_STROBE];
      else
        pdOe <= ~ctrlQ[`CTL_DIR];
      strobeOut_n     <= ~ctrlQ[`CTL_STROBE];
      lineFeedOut_n   <= ~ctrlQ[`CTL_FEED];
      initOut         <= ctrlQ[`CTL_INIT];
      selectInOut_n   <= ~ctrlQ[`CTL_SELIN];
      irqEnable       <= ctrlQ[`CTL_IRQEN];
      eppWriteOut_n   <= ~((stQ != ST_IDLE) && (eppWrQ | ctrlQ[`CTL_STROBE]));
      eppDataStbOut_n <= ~(stQ == ST_STB && !eppAddrQ);
      eppAddrStbOut_n <= ~(stQ == ST_STB && eppAddrQ);
    end
  end
endmodule // parallel_port_regs
`default_nettype wire

//--- pport_chk_sva.sv
// Assertion checker for the parallel port host registers
`timescale 1ns/1ps
`default_nettype none
module pport_chk #(parameter [11:0] EPP_TMO_CYCLES = 12'h9C4) (
  // Clock, reset and mode
  input wire logic       core_clk, rst_n,
  input wire logic [1:0] portMode,
  // Host side and pins
  input wire logic       hostReq, hostWrite, hostReady, rdValid, rdReady, pdOe,
  input wire logic       strobeOut_n, lineFeedOut_n, initOut, selectInOut_n, irqEnable,
  input wire logic       eppDataStbOut_n, eppAddrStbOut_n,
  input wire logic [2:0] hostAddr,
  input wire logic [7:0] hostWdata, rdData, pdOut
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic take = hostReq && hostReady;
  wire logic rdGo = take && !hostWrite && !rdValid;
  logic [12:0] stallCnt_q;
  // Stall length of one EPP cycle; any byte waiting in the read buffer restarts it
  always @(posedge core_clk or negedge rst_n)
    if (!rst_n) stallCnt_q <= 13'h0000;
    else stallCnt_q <= (hostReady || rdValid) ? 13'h0000 : stallCnt_q + 13'h0001;
  ctl_pins_a:
    assert property (take && hostWrite && hostAddr == 3'h2 |-> ##2 {irqEnable, selectInOut_n,
      initOut, lineFeedOut_n, strobeOut_n} == ($past(hostWdata[4:0], 2) ^ 5'h0B))
      else $error("control pins wrong");
  data_pins_a:
    assert property (take && hostWrite && hostAddr == 3'h0 |-> ##2 pdOut == $past(hostWdata, 2))
      else $error("data pins wrong");
  mode_dir_a:
    assert property (portMode == 2'h0 && $past(portMode) == 2'h0 |-> pdOe)
      else $error("printer mode not driving");
  rd_lat_a:
    assert property (rdGo && hostAddr < 3'h3 |=> rdValid) else $error("read not answered");
  rd_hold_a:
    assert property (rdValid && !rdReady |=> rdValid && $stable(rdData))
      else $error("read answer not held");
  off_zero_a:
    assert property (rdGo && hostAddr >= 3'h3 && portMode != 2'h2 |=> rdValid && rdData == 8'h00)
      else $error("absent port read not zero");
  sts_rsvd_a:
    assert property (rdGo && hostAddr == 3'h1 |=> rdData[2:1] == 2'h0)
      else $error("status bits 1-2 not zero");
  epp_hold_a:
    assert property (take && hostWrite && hostAddr >= 3'h3 && portMode == 2'h2 |=> !hostReady)
      else $error("EPP write did not stall");
  stb_mode_a:
    assert property (!(eppDataStbOut_n && eppAddrStbOut_n) |-> portMode == 2'h2)
      else $error("EPP strobe outside EPP mode");
  tmo_bound_a:
    assert property (stallCnt_q <= EPP_TMO_CYCLES + 13'h0008) else $error("EPP cycle overran");
  cover property (rdGo && hostAddr == 3'h1);
  cover property (stallCnt_q == {1'b0, EPP_TMO_CYCLES});
  cover property (!eppAddrStbOut_n);
endmodule // pport_chk
bind parallel_port_regs pport_chk #(.EPP_TMO_CYCLES(EPP_TMO_CYCLES)) chk (.*);
`default_nettype wire

//--- pport_peer.sv
// Peripheral model: EPP wait handshake and data line drive
`timescale 1ns/1ps
`default_nettype none
module pport_peer (
  // Inputs from the port and the bench
  input wire logic       core_clk, pdOe, eppDataStbOut_n, eppAddrStbOut_n,
  input wire logic [7:0] pdOut, peerByte,
  input var  int         lag,
  // Lines the peripheral drives
  output var logic       waitInput,
  output wire logic [7:0] pdIn
);
  int waitCnt = 0;
  // Wait idles low, rises lag cycles into a strobe; a huge lag forces a timeout
  initial waitInput = 1'b0;
  always @(posedge core_clk) begin
    waitCnt <= (eppDataStbOut_n && eppAddrStbOut_n) ? 0 : waitCnt + 1;
    waitInput <= !(eppDataStbOut_n && eppAddrStbOut_n) && waitCnt >= lag;
  end
  // Port drive wins; a released bus shows the peripheral's byte
  assign pdIn = pdOe ? pdOut : peerByte;
endmodule // pport_peer
`default_nettype wire

//--- parallel_port_regs_tb.sv
// Self-checking bench for the parallel port host registers
`timescale 1ns/1ps
`default_nettype none
module parallel_port_regs_tb;
  logic core_clk, rst_n, hostReq, hostWrite, rdReady, pdOe, waitInput, hostReady, rdValid;
  logic faultInput, onlineInput, mediaInput, ackInput, busyInput, addrSeen, dataSeen;
  logic strobeOut_n, lineFeedOut_n, initOut, selectInOut_n, irqEnable;
  logic eppWriteOut_n, eppDataStbOut_n, eppAddrStbOut_n;
  logic [1:0] portMode;
  logic [2:0] hostAddr;
  logic [7:0] hostWdata, rdData, pdIn, pdOut, peerByte, v, w, eppByte;
  int seed = 32'hF370EBD0;
  int mismatches = 0, cmp_count = 0, lag = 0, i;
  parallel_port_regs #(.EPP_TMO_CYCLES(12'h014)) uut (.*);
  pport_peer peer (.*);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Record strobe kind and bus byte of each EPP cycle
  always @(negedge core_clk) begin
    if (!eppAddrStbOut_n) addrSeen = 1'b1;
    if (!eppDataStbOut_n) dataSeen = 1'b1;
    if (!(eppAddrStbOut_n && eppDataStbOut_n)) eppByte = pdOut;
  end
  task chk(input logic [7:0] s, e, input string nm);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One host request, held until the port takes it
  task acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {hostReq, hostWrite, hostAddr, hostWdata} = {1'b1, wr, a, d};
    for (i = 0; i < 3000 && hostReady !== 1'b1; i++) @(negedge core_clk);
    @(negedge core_clk);
    hostReq = 1'b0;
  endtask
  task pop(output logic [7:0] r);
    for (i = 0; i < 3000 && rdValid !== 1'b1; i++) @(negedge core_clk);
    r = rdData;
    @(negedge core_clk);
  endtask
  task rd(input logic [2:0] a, output logic [7:0] r);
    acc(1'b0, a, 8'h00);
    pop(r);
  endtask
  function logic [7:0] sts(input logic t);
    return {~busyInput, ackInput, mediaInput, onlineInput, faultInput, 2'h0, t};
  endfunction
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end
  initial begin
    {rst_n, hostReq, hostWrite, hostAddr, hostWdata, portMode, peerByte} = '0;
    {faultInput, onlineInput, mediaInput, ackInput, busyInput, addrSeen, dataSeen} = '0;
    rdReady = 1'b1;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    chk({pdOe, strobeOut_n, lineFeedOut_n, initOut, selectInOut_n, irqEnable, 2'h0}, 8'hE8,
      "reset pins");
    chk(pdOut, 8'h00, "reset data");
    // Random traffic in printer and bidirectional modes
    for (int n = 0; n < 40; n++) begin
      @(negedge core_clk);
      w = 8'($random(seed));
      {faultInput, onlineInput, mediaInput, ackInput, busyInput} = w[7:3];
      portMode = {1'b0, n[0]};
      peerByte = 8'($random(seed));
      acc(1'b1, 3'h0, w);
      acc(1'b1, 3'h2, w);
      acc(1'b1, 3'h4, ~w);
      repeat (3) @(negedge core_clk);
      chk(pdOut, w, "data pins");
      rd(3'h0, v);
      chk(v, (n[0] && w[5]) ? peerByte : w, "line read");
      rd(3'h2, v);
      chk(v, {2'h0, w[5:0]}, "control read");
      rd(3'h1, v);
      chk(v, sts(1'b0), "status read");
      rd(3'(3 + n % 5), v);
      chk(v, 8'h00, "absent port");
    end
    $display("test standard modes done");
    // EPP cycles on every EPP port, prompt and slow
    portMode = 2'h2;
    for (int n = 3; n < 8; n++) begin
      w = 8'($random(seed));
      {addrSeen, dataSeen, lag} = {2'h0, n - 3};
      acc(1'b1, 3'h2, 8'h04);
      acc(1'b1, 3'(n), w);
      acc(1'b1, 3'h2, 8'h24);
      chk({6'h00, addrSeen, dataSeen}, (n == 3) ? 8'h02 : 8'h01, "strobe kind");
      chk(eppByte, w, "EPP byte");
      peerByte = ~w;
      rd(3'(n), v);
      chk(v, ~w, "EPP read");
    end
    $display("test EPP cycles done");
    // Timeout set, kept by a zero write, hidden outside EPP, cleared by a one
    lag = 1000;
    acc(1'b1, 3'h2, 8'h04);
    acc(1'b1, 3'h4, 8'h5A);
    rd(3'h1, v);
    lag = 0;
    chk(v, sts(1'b1), "timeout set");
    acc(1'b1, 3'h1, 8'h00);
    rd(3'h1, v);
    chk(v, sts(1'b1), "zero write");
    portMode = 2'h0;
    rd(3'h1, v);
    chk(v, sts(1'b0), "timeout hidden");
    portMode = 2'h2;
    acc(1'b1, 3'h1, 8'h01);
    rd(3'h1, v);
    chk(v, sts(1'b0), "timeout cleared");
    lag = 1000;
    rd(3'h4, v);
    chk(v, 8'h00, "aborted read");
    lag = 0;
    $display("test timeout done");
    // Read buffer filled while the drain side stalls, then drained in order
    portMode = 2'h0;
    acc(1'b1, 3'h0, 8'hA5);
    acc(1'b1, 3'h2, 8'h2C);
    repeat (3) @(negedge core_clk);
    rdReady = 1'b0;
    acc(1'b0, 3'h0, 8'h00);
    acc(1'b0, 3'h2, 8'h00);
    chk({7'h00, hostReady}, 8'h00, "buffer full");
    rdReady = 1'b1;
    pop(v);
    chk(v, 8'hA5, "first drained");
    pop(v);
    chk(v, 8'h2C, "second drained");
    $display("test buffer done");
    wrap_up;
  end
endmodule // parallel_port_regs_tb
`default_nettype wire
